// ===== hdlc_cmd_event.sv
// command decoding, event flags and pool control of the layer-2 hdlc controller
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module hdlc_cmd_event #(
  parameter int T200_CYCLES = hdlc_cmd_pkg::T200_CYCLES_DEFAULT,
  parameter int EXT_TIMER_CYCLES = hdlc_cmd_pkg::EXT_TIMER_CYCLES_DEFAULT,
  parameter int N200 = hdlc_cmd_pkg::N200_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire hdlc_cmd_pkg::rx_hdr_type rx_hdr,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_abort,
  output hdlc_cmd_pkg::tx_info_type tx_info,
  input wire logic tx_ready,
  input wire logic tx_error,
  output logic ack_req,
  output logic ack_rnr
);

  logic access_end, wr_ev, rd_ev, addr_ok;
  logic [31:0] rd_mux;
  logic [7:0] status, status_full, status_view, ext, mask, st_set, ex_set;
  logic mode_auto;
  logic [7:0] cmd;
  logic cmd_wr, cmd_rx_complete, cmd_rx_reset, cmd_rx_not_ready, cmd_timer_start;
  logic cmd_tx_reset, cmd_tx_any, cmd_close, cmd_iframe;
  logic [5:0] rx_wr, rx_rd;
  logic rx_pending, rx_drop, rx_byte_ok;
  logic [7:0] rx_rd_data, tx_rd_data;
  logic ev_rme, ev_rpf, ev_rfo, ev_pce, ev_rsc, ev_xpr, ev_xdu, ev_xmr, ev_t200, ev_tin_ext;
  logic [2:0] vs, vr;
  logic peer_busy, rnr_mode;
  logic hdr_end, fr_i, fr_s, nr_ok, s_ok, peer_ack, peer_rej;
  hdlc_cmd_pkg::tx_state_type tx_state;
  logic [5:0] tx_wr, tx_rd, tx_base, tx_end, tx_count;
  logic tx_close, tx_iframe, txdata_wr, tx_in_frame;
  logic [15:0] t200_cnt, ext_cnt;
  logic [3:0] retry;
  logic ext_run;

  // apb handshake: one wait state gives registered read data time to settle
  assign access_end = psel & penable & pready;
  assign wr_ev = access_end & pwrite;
  assign rd_ev = access_end & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel & penable & ~pready) begin
        prdata <= rd_mux;
      end
    end
  end

  // masked primary bits stay hidden and pending; summary bits always show
  assign status_full = status | {7'h00, |ext};
  assign status_view = status_full & ~(mask & ~hdlc_cmd_pkg::ST_SUMMARY_BITS);

  // read decode; the command location always reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == hdlc_cmd_pkg::ADDR_STATUS) begin
      rd_mux = {24'h00_0000, status_view};
    end else if (paddr == hdlc_cmd_pkg::ADDR_MASK) begin
      rd_mux = {24'h00_0000, mask};
    end else if (paddr == hdlc_cmd_pkg::ADDR_EXT) begin
      rd_mux = {24'h00_0000, ext};
    end else if (paddr == hdlc_cmd_pkg::ADDR_CMD) begin
      rd_mux = 32'h0000_0000;
    end else if (paddr == hdlc_cmd_pkg::ADDR_TXDATA) begin
      rd_mux = {26'h0, tx_count};
    end else if (paddr == hdlc_cmd_pkg::ADDR_RXDATA) begin
      rd_mux = {24'h00_0000, rx_rd_data};
    end else if (paddr == hdlc_cmd_pkg::ADDR_MODE) begin
      rd_mux = {31'h0, mode_auto};
    end else if (paddr == hdlc_cmd_pkg::ADDR_INFO) begin
      rd_mux = {16'h0000, vs, vr, peer_busy, rnr_mode, 2'h0, rx_wr};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // command strobes live for the one access edge only, nothing is stored
  assign cmd = pwdata[7:0];
  assign cmd_wr = wr_ev & (paddr == hdlc_cmd_pkg::ADDR_CMD);
  assign cmd_rx_complete = cmd_wr & (cmd == hdlc_cmd_pkg::CMD_RX_MESSAGE_COMPLETE);
  assign cmd_rx_reset = cmd_wr & (cmd == hdlc_cmd_pkg::CMD_RX_RESET);
  assign cmd_rx_not_ready = cmd_wr & (cmd == hdlc_cmd_pkg::CMD_RX_NOT_READY);
  assign cmd_timer_start = cmd_wr & (cmd == hdlc_cmd_pkg::CMD_TIMER_START);
  assign cmd_tx_reset = cmd_wr & (cmd == hdlc_cmd_pkg::CMD_TX_RESET);
  assign cmd_close = (cmd == hdlc_cmd_pkg::CMD_TX_TRANSPARENT_CLOSE) |
                     (cmd == hdlc_cmd_pkg::CMD_TX_IFRAME_CLOSE);
  assign cmd_iframe = (cmd == hdlc_cmd_pkg::CMD_TX_IFRAME_CLOSE) |
                      (cmd == hdlc_cmd_pkg::CMD_TX_IFRAME);
  assign cmd_tx_any = cmd_wr & (cmd_close | cmd_iframe |
                      (cmd == hdlc_cmd_pkg::CMD_TX_TRANSPARENT));

  // mode and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_auto <= hdlc_cmd_pkg::MODE_AUTO_RESET;
      mask <= hdlc_cmd_pkg::MASK_RESET;
    end else begin
      if (wr_ev & (paddr == hdlc_cmd_pkg::ADDR_MODE)) begin
        mode_auto <= pwdata[hdlc_cmd_pkg::MODE_AUTO_BIT];
      end
      if (wr_ev & (paddr == hdlc_cmd_pkg::ADDR_MASK)) begin
        mask <= pwdata[7:0];
      end
    end
  end

  // event vectors into the two status registers
  always_comb begin
    st_set = 8'h00;
    ex_set = 8'h00;
    st_set[hdlc_cmd_pkg::ST_RX_MESSAGE_END] = ev_rme;
    st_set[hdlc_cmd_pkg::ST_RX_POOL_FULL] = ev_rpf;
    st_set[hdlc_cmd_pkg::ST_RX_STATUS_CHANGE] = ev_rsc;
    st_set[hdlc_cmd_pkg::ST_TX_POOL_READY] = ev_xpr;
    st_set[hdlc_cmd_pkg::ST_TIMER_EXPIRED] = ev_t200 | ev_tin_ext;
    ex_set[hdlc_cmd_pkg::EX_TX_MESSAGE_REPEAT] = ev_xmr;
    ex_set[hdlc_cmd_pkg::EX_TX_DATA_UNDERRUN] = ev_xdu;
    ex_set[hdlc_cmd_pkg::EX_PROTOCOL_ERROR] = ev_pce;
    ex_set[hdlc_cmd_pkg::EX_RX_FRAME_OVERFLOW] = ev_rfo;
  end

  // sticky flags: read clears the shown bits, write one clears; a set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= hdlc_cmd_pkg::STATUS_RESET;
    end else if (rd_ev & (paddr == hdlc_cmd_pkg::ADDR_STATUS)) begin
      status <= (status & ~(status_view & ~hdlc_cmd_pkg::ST_SUMMARY_BITS)) | st_set;
    end else if (wr_ev & (paddr == hdlc_cmd_pkg::ADDR_STATUS)) begin
      status <= (status & ~(pwdata[7:0] & ~hdlc_cmd_pkg::ST_SUMMARY_BITS)) | st_set;
    end else begin
      status <= status | st_set;
    end
  end

  // extended flags; the summary bit is simply the or of this register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext <= hdlc_cmd_pkg::EXT_RESET;
    end else if (rd_ev & (paddr == hdlc_cmd_pkg::ADDR_EXT)) begin
      ext <= ex_set;
    end else if (wr_ev & (paddr == hdlc_cmd_pkg::ADDR_EXT)) begin
      ext <= (ext & ~pwdata[7:0]) | ex_set;
    end else begin
      ext <= ext | ex_set;
    end
  end

  // level interrupt while any unmasked bit is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_full & ~mask);
    end
  end

  // external timer, restarted by each start command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_run <= 1'b0;
      ext_cnt <= 16'h0000;
      ev_tin_ext <= 1'b0;
    end else begin
      ev_tin_ext <= 1'b0;
      if (cmd_timer_start) begin
        ext_run <= 1'b1;
        ext_cnt <= 16'h0000;
      end else if (ext_run) begin
        ext_cnt <= ext_cnt + 16'h0001;
        if (ext_cnt == 16'(EXT_TIMER_CYCLES - 1)) begin
          ext_run <= 1'b0;
          ev_tin_ext <= 1'b1;
        end
      end
    end
  end

  // receive pool: one block waits for the host at a time; a byte that finds
  // the pool locked drops the rest of its frame, the cost of a single pool
  assign rx_byte_ok = rx_valid & ~rx_pending & ~rx_drop & (rx_wr != hdlc_cmd_pkg::FIFO_FULL);

  fifo_mem rx_pool (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rx_byte_ok),
    .wr_addr(rx_wr[4:0]),
    .wr_data(rx_data),
    .rd_addr(rx_rd[4:0]),
    .rd_data(rx_rd_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr <= 6'h00;
      rx_rd <= 6'h00;
      rx_pending <= 1'b0;
      rx_drop <= 1'b0;
      ev_rme <= 1'b0;
      ev_rpf <= 1'b0;
      ev_rfo <= 1'b0;
    end else begin
      ev_rme <= 1'b0;
      ev_rpf <= 1'b0;
      ev_rfo <= 1'b0;
      if (rd_ev & (paddr == hdlc_cmd_pkg::ADDR_RXDATA) & (rx_rd != rx_wr)) begin
        rx_rd <= rx_rd + 6'h01;
      end
      if (rx_byte_ok) begin
        rx_wr <= rx_wr + 6'h01;
        if (rx_last) begin
          ev_rme <= 1'b1;
          rx_pending <= 1'b1;
        end else if (rx_wr == hdlc_cmd_pkg::FIFO_FULL - 6'h01) begin
          ev_rpf <= 1'b1;
          rx_pending <= 1'b1;
        end
      end else if (rx_valid) begin
        if (rx_last) begin
          ev_rfo <= 1'b1;
          rx_drop <= 1'b0;
        end else begin
          rx_drop <= 1'b1;
        end
      end
      if (cmd_rx_complete | cmd_rx_reset) begin
        rx_wr <= 6'h00;
        rx_rd <= 6'h00;
        rx_pending <= 1'b0;
      end
      if (cmd_rx_reset) begin
        rx_drop <= 1'b0;
      end
    end
  end

  // auto-mode header checks, taken with the last byte of each frame
  assign hdr_end = rx_valid & rx_last & mode_auto;
  assign fr_i = hdr_end & (rx_hdr.kind == hdlc_cmd_pkg::KIND_I);
  assign fr_s = hdr_end & (rx_hdr.kind == hdlc_cmd_pkg::KIND_S);
  assign nr_ok = (rx_hdr.nr == vs) |
                 ((tx_state == hdlc_cmd_pkg::TX_ACK_WAIT) & (rx_hdr.nr == vs - 3'h1));
  assign s_ok = fr_s & nr_ok & ~rx_hdr.has_info;
  assign peer_ack = (fr_i & nr_ok | s_ok) & (rx_hdr.nr == vs);
  assign peer_rej = s_ok & (rx_hdr.s_code == hdlc_cmd_pkg::S_REJ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vr <= 3'h0;
      peer_busy <= 1'b0;
      rnr_mode <= 1'b0;
      ev_pce <= 1'b0;
      ev_rsc <= 1'b0;
      ack_req <= 1'b0;
      ack_rnr <= 1'b0;
    end else begin
      ev_pce <= 1'b0;
      ev_rsc <= 1'b0;
      ack_req <= 1'b0;
      if (cmd_rx_not_ready & mode_auto) begin
        rnr_mode <= 1'b1;
      end
      if ((fr_i | fr_s) & (~nr_ok | (fr_s & rx_hdr.has_info))) begin
        ev_pce <= 1'b1;
      end
      if (fr_i & nr_ok & ~rnr_mode) begin
        vr <= vr + 3'h1;
      end
      if (fr_i | (fr_s & rnr_mode)) begin
        ack_req <= 1'b1;
        ack_rnr <= rnr_mode;
      end
      if (s_ok & (rx_hdr.s_code != hdlc_cmd_pkg::S_REJ) &
          ((rx_hdr.s_code == hdlc_cmd_pkg::S_RNR) != peer_busy)) begin
        peer_busy <= rx_hdr.s_code == hdlc_cmd_pkg::S_RNR;
        ev_rsc <= 1'b1;
      end
      if (cmd_rx_reset) begin
        rnr_mode <= 1'b0;
        if (mode_auto) begin
          vr <= 3'h0;
        end
      end
    end
  end

  // transmit pool; space of a frame is held from its base until it is done
  assign tx_count = tx_wr - tx_base;
  assign txdata_wr = wr_ev & (paddr == hdlc_cmd_pkg::ADDR_TXDATA) &
                     (tx_count != hdlc_cmd_pkg::FIFO_FULL);
  assign tx_in_frame = (tx_state != hdlc_cmd_pkg::TX_IDLE) &
                       (tx_state != hdlc_cmd_pkg::TX_ACK_WAIT);

  fifo_mem tx_pool (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(txdata_wr),
    .wr_addr(tx_wr[4:0]),
    .wr_data(pwdata[7:0]),
    .rd_addr(tx_rd[4:0]),
    .rd_data(tx_rd_data)
  );

  // transmit sequencer, send counter, T200 and retry count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= hdlc_cmd_pkg::TX_IDLE;
      tx_wr <= 6'h00;
      tx_rd <= 6'h00;
      tx_base <= 6'h00;
      tx_end <= 6'h00;
      tx_close <= 1'b0;
      tx_iframe <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      tx_abort <= 1'b0;
      tx_info <= '0;
      vs <= 3'h0;
      t200_cnt <= 16'h0000;
      retry <= 4'h0;
      ev_xpr <= 1'b0;
      ev_xdu <= 1'b0;
      ev_xmr <= 1'b0;
      ev_t200 <= 1'b0;
    end else begin
      ev_xpr <= 1'b0;
      ev_xdu <= 1'b0;
      ev_xmr <= 1'b0;
      ev_t200 <= 1'b0;
      tx_abort <= 1'b0;
      if (txdata_wr) begin
        tx_wr <= tx_wr + 6'h01;
      end
      if (cmd_tx_reset) begin
        tx_state <= hdlc_cmd_pkg::TX_IDLE;
        tx_wr <= 6'h00;
        tx_rd <= 6'h00;
        tx_base <= 6'h00;
        tx_end <= 6'h00;
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        ev_xpr <= 1'b1;
      end else if (cmd_tx_any & ((tx_state == hdlc_cmd_pkg::TX_IDLE) |
                                 (tx_state == hdlc_cmd_pkg::TX_HOLD))) begin
        tx_end <= tx_wr;
        tx_close <= cmd_close;
        tx_iframe <= cmd_iframe;
        tx_state <= hdlc_cmd_pkg::TX_FETCH;
      end else if (tx_error & tx_in_frame) begin
        tx_rd <= tx_base;
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        ev_xmr <= 1'b1;
        tx_state <= hdlc_cmd_pkg::TX_FETCH;
      end else begin
        case (tx_state)
          hdlc_cmd_pkg::TX_FETCH: begin
            if (tx_rd == tx_end) begin
              tx_base <= tx_rd;
              ev_xpr <= 1'b1;
              tx_state <= hdlc_cmd_pkg::TX_IDLE;
            end else begin
              tx_state <= hdlc_cmd_pkg::TX_LOAD;
            end
          end
          hdlc_cmd_pkg::TX_LOAD: begin
            tx_data <= tx_rd_data;
            tx_valid <= 1'b1;
            tx_last <= tx_close & (tx_rd + 6'h01 == tx_end);
            tx_info <= {tx_iframe & mode_auto, vs};
            tx_state <= hdlc_cmd_pkg::TX_SEND;
          end
          hdlc_cmd_pkg::TX_SEND: begin
            if (tx_ready) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              tx_rd <= tx_rd + 6'h01;
              if (tx_rd + 6'h01 != tx_end) begin
                tx_state <= hdlc_cmd_pkg::TX_FETCH;
              end else if (!tx_close) begin
                tx_base <= tx_rd + 6'h01; // sent bytes of an open frame are released
                ev_xpr <= 1'b1;
                tx_state <= hdlc_cmd_pkg::TX_HOLD;
              end else if (tx_iframe & mode_auto) begin
                vs <= vs + 3'h1;
                t200_cnt <= 16'h0000;
                retry <= 4'h0;
                tx_state <= hdlc_cmd_pkg::TX_ACK_WAIT;
              end else begin
                tx_base <= tx_rd + 6'h01;
                ev_xpr <= 1'b1;
                tx_state <= hdlc_cmd_pkg::TX_IDLE;
              end
            end
          end
          hdlc_cmd_pkg::TX_HOLD: begin
            if (tx_ready) begin
              tx_abort <= 1'b1;
              ev_xdu <= 1'b1;
              tx_base <= tx_wr;
              tx_rd <= tx_wr;
              tx_state <= hdlc_cmd_pkg::TX_IDLE;
            end
          end
          hdlc_cmd_pkg::TX_ACK_WAIT: begin
            t200_cnt <= t200_cnt + 16'h0001;
            if (peer_ack) begin
              tx_base <= tx_rd;
              ev_xpr <= 1'b1;
              tx_state <= hdlc_cmd_pkg::TX_IDLE;
            end else if (peer_rej) begin
              tx_rd <= tx_base;
              vs <= vs - 3'h1;
              ev_xmr <= 1'b1;
              tx_state <= hdlc_cmd_pkg::TX_FETCH;
            end else if (t200_cnt == 16'(T200_CYCLES - 1)) begin
              t200_cnt <= 16'h0000;
              if (retry == 4'(N200 - 1)) begin
                tx_base <= tx_rd;
                ev_t200 <= 1'b1;
                tx_state <= hdlc_cmd_pkg::TX_IDLE;
              end else begin
                retry <= retry + 4'h1;
                tx_rd <= tx_base;
                vs <= vs - 3'h1;
                tx_state <= hdlc_cmd_pkg::TX_FETCH;
              end
            end
          end
          default: begin
            tx_state <= hdlc_cmd_pkg::TX_IDLE;
          end
        endcase
      end
      if (cmd_rx_reset & mode_auto) begin
        vs <= 3'h0;
      end
    end
  end

endmodule

// ===== hdlc_cmd_pkg.sv
// shared constants, types and register map of the hdlc command and event logic
package hdlc_cmd_pkg;

  // fifo geometry
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam logic [5:0] FIFO_FULL = 6'h20;

  // apb byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_EXT = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_RXDATA = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_INFO = 8'h1C;

  // primary status bit positions
  localparam int ST_RX_MESSAGE_END = 7;
  localparam int ST_RX_POOL_FULL = 6;
  localparam int ST_RX_STATUS_CHANGE = 5;
  localparam int ST_TX_POOL_READY = 4;
  localparam int ST_TIMER_EXPIRED = 3;
  localparam int ST_CI_CHANGE = 2;
  localparam int ST_EXT_SUMMARY = 0;
  localparam logic [7:0] ST_SUMMARY_BITS = 8'h05;

  // extended status bit positions
  localparam int EX_TX_MESSAGE_REPEAT = 7;
  localparam int EX_TX_DATA_UNDERRUN = 6;
  localparam int EX_PROTOCOL_ERROR = 5;
  localparam int EX_RX_FRAME_OVERFLOW = 4;

  // mode register field
  localparam int MODE_AUTO_BIT = 0;

  // values after reset
  localparam logic [7:0] STATUS_RESET = 8'h10;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic MODE_AUTO_RESET = 1'b0;

  // command codes
  localparam logic [7:0] CMD_RX_MESSAGE_COMPLETE = 8'h80;
  localparam logic [7:0] CMD_RX_RESET = 8'h40;
  localparam logic [7:0] CMD_RX_NOT_READY = 8'h20;
  localparam logic [7:0] CMD_TIMER_START = 8'h10;
  localparam logic [7:0] CMD_TX_TRANSPARENT_CLOSE = 8'h0A;
  localparam logic [7:0] CMD_TX_IFRAME_CLOSE = 8'h06;
  localparam logic [7:0] CMD_TX_TRANSPARENT = 8'h08;
  localparam logic [7:0] CMD_TX_IFRAME = 8'h04;
  localparam logic [7:0] CMD_TX_RESET = 8'h01;

  // supervisory frame codes
  localparam logic [1:0] S_RR = 2'h0;
  localparam logic [1:0] S_RNR = 2'h1;
  localparam logic [1:0] S_REJ = 2'h2;

  // timing at a 100 ns clock; least times round up
  localparam int CLK_PERIOD_NS = 100;
  localparam int T200_NS = 1000000;
  localparam int EXT_TIMER_NS = 1000000;
  localparam int T200_CYCLES_DEFAULT = (T200_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_TIMER_CYCLES_DEFAULT = (EXT_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int N200_DEFAULT = 3;

  typedef enum logic [1:0] {
    KIND_I = 2'h0,
    KIND_S = 2'h1,
    KIND_U = 2'h2
  } frame_kind_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_FETCH = 3'h1,
    TX_LOAD = 3'h2,
    TX_SEND = 3'h3,
    TX_HOLD = 3'h4,
    TX_ACK_WAIT = 3'h5
  } tx_state_type;

  // frame header, valid with the last byte of a received frame
  typedef struct packed {
    frame_kind_type kind;
    logic [1:0] s_code;
    logic [2:0] nr;
    logic has_info;
  } rx_hdr_type;

  // kind and send number of the frame on the line
  typedef struct packed {
    logic iframe;
    logic [2:0] ns;
  } tx_info_type;

endpackage

// ===== fifo_mem.sv
// 32 x 8 storage with registered read data, used for both pools
`timescale 1ns/1ps
module fifo_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [hdlc_cmd_pkg::PTR_W-1:0] wr_addr,
  input wire logic [hdlc_cmd_pkg::DATA_W-1:0] wr_data,
  input wire logic [hdlc_cmd_pkg::PTR_W-1:0] rd_addr,
  output logic [hdlc_cmd_pkg::DATA_W-1:0] rd_data
);

  logic [hdlc_cmd_pkg::DATA_W-1:0] mem [hdlc_cmd_pkg::FIFO_DEPTH];

  // array itself needs no reset; readers never look past the write pointer
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data follows the address one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ===== hdlc_cmd_event_asserts.sv
// port assertions of the hdlc command and event logic
`timescale 1ns/1ps
module hdlc_cmd_event_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_abort
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // command location answered at this edge
  logic cmd_acc;
  assign cmd_acc = pready && psel && paddr == 8'h0C;
  AST_READY_DUE: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  AST_READY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready not one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  AST_CMD_READS_ZERO: assert property (cmd_acc && !pwrite |-> prdata == 32'h0)
    else $error("command location reads nonzero");
  AST_TX_HOLDS: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("byte withdrawn before taken");
  AST_TX_GAP: assert property (tx_valid && tx_ready |=> !tx_valid [*2])
    else $error("byte offered again at once");
  AST_TX_RESET_QUIET: assert property (
    cmd_acc && pwrite && pwdata[7:0] == 8'h01 |=> !tx_valid [*3])
    else $error("transmitter busy after reset");
  AST_ABORT_FLAGGED: assert property (tx_abort |-> !tx_valid ##[1:4] irq)
    else $error("abort without interrupt");
endmodule

bind hdlc_cmd_event hdlc_cmd_event_asserts u_asserts (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .tx_valid, .tx_ready, .tx_abort);

// ===== hdlc_line_model.sv
// peer station model: takes offered bytes and sends received frames
`timescale 1ns/1ps
module hdlc_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic slow,
  input wire logic demand,
  output logic tx_ready,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'hA5,
  output logic rx_last = 1'b0,
  output hdlc_cmd_pkg::rx_hdr_type rx_hdr = '0
);
  logic [8:0] got[$];
  logic pace;
  // registered take, so each byte gets one ready pulse; slow lets ready rise only on alternate edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      pace <= 1'b0;
    end else begin
      pace <= ~pace;
      tx_ready <= demand || (tx_valid && !tx_ready && (!slow || pace));
    end
  end
  // bytes taken by the line, close flag on top
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back({tx_last, tx_data});
    end
  end
  // one received byte; the released data line shows the inverse
  task automatic send(input logic [7:0] b, input logic last,
    input hdlc_cmd_pkg::rx_hdr_type h = '0);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_last <= last;
    rx_hdr <= h;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule

// ===== test_hdlc_cmd_event.sv
// self-checking bench of the hdlc command and event logic
`timescale 1ns/1ps
module test_hdlc_cmd_event;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slow = 1'b0, demand = 1'b0, tx_error = 1'b0, errflag;
  logic [7:0] paddr = 8'h00, b, tx_data, rx_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, tx_valid, tx_last, tx_abort, tx_ready, rx_valid, rx_last, ack_rnr;
  hdlc_cmd_pkg::rx_hdr_type rx_hdr;
  logic [8:0] exp_tx[$];
  logic [7:0] exp_rx[$];
  int err_total = 0, tests_run = 0, seed = 32'h71CE, n, i, k;

  hdlc_cmd_event #(.T200_CYCLES(20), .EXT_TIMER_CYCLES(16), .N200(3)) u_hdlc_cmd_event (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .rx_valid, .rx_data, .rx_last, .rx_hdr, .tx_valid, .tx_data, .tx_last, .tx_abort,
    .tx_info(), .tx_ready, .tx_error, .ack_req(), .ack_rnr);
  hdlc_line_model u_line (.pclk, .presetn, .tx_valid, .tx_data, .tx_last, .slow, .demand,
    .tx_ready, .rx_valid, .rx_data, .rx_last, .rx_hdr);

  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  task conclude;
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer, held until pready is sampled; a hung slave ends the run
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    rd = prdata;
    errflag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (c >= 50) begin
      err_total++;
      conclude;
    end
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // bounded wait for bytes on the line, then let the flags settle
  task wait_tx(input int m);
    int c;
    c = 0;
    while (u_line.got.size() < m && c < 500) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 500) begin
      err_total++;
      conclude;
    end
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("status", 8'h00, {24'h0, hdlc_cmd_pkg::STATUS_RESET});
    rdchk("status", 8'h00, 32'h0);
    rdchk("cmd", 8'h0C, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("slverr", errflag, 1'b1);
    // closing transparent frames, prompt line then slow line
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      n = 1 + ($random(seed) & 7);
      u_line.got.delete();
      exp_tx.delete();
      for (i = 0; i < n; i++) begin
        b = $random(seed);
        exp_tx.push_back({i == n - 1, b});
        apb(1'b1, 8'h10, {24'h0, b});
      end
      apb(1'b1, 8'h0C, 32'h0A);
      wait_tx(n);
      for (i = 0; i < n; i++) chk("tx byte", u_line.got[i], exp_tx[i]);
      rdchk("status", 8'h00, 32'h10);
    end
    // open block drains, then the line demands more: underrun
    u_line.got.delete();
    apb(1'b1, 8'h10, 32'h5A);
    apb(1'b1, 8'h10, 32'hC3);
    apb(1'b1, 8'h0C, 32'h08);
    wait_tx(2);
    chk("open close", u_line.got[1], 9'h0C3);
    rdchk("status", 8'h00, 32'h10);
    tx_error <= 1'b1;
    @(posedge pclk);
    tx_error <= 1'b0;
    apb(1'b1, 8'h10, 32'h77);
    apb(1'b1, 8'h0C, 32'h08);
    wait_tx(3);
    demand <= 1'b1;
    repeat (3) @(posedge pclk);
    demand <= 1'b0;
    repeat (4) @(posedge pclk);
    rdchk("ext", 8'h08, 32'hC0);
    rdchk("ext", 8'h08, 32'h0);
    apb(1'b1, 8'h10, 32'h11);
    apb(1'b1, 8'h0C, 32'h01);
    rdchk("tx held", 8'h10, 32'h0);
    // pool ready masked; a held frame makes the next one overflow
    apb(1'b1, 8'h04, 32'h10);
    for (i = 0; i < 5; i++) begin
      b = $random(seed);
      if (i < 3) exp_rx.push_back(b);
      u_line.send(b, i == 2 || i == 4);
    end
    repeat (4) @(posedge pclk);
    rdchk("status", 8'h00, 32'h81);
    rdchk("ext", 8'h08, 32'h10);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b0);
    for (i = 0; i < 3; i++) rdchk("rx byte", 8'h14, {24'h0, exp_rx[i]});
    apb(1'b1, 8'h0C, 32'h80);
    apb(1'b0, 8'h1C, 32'h0);
    chk("rx count", rd[5:0], 6'h0);
    u_line.send(8'h3C, 1'b0);
    u_line.send(8'h96, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h1C, 32'h0);
    chk("rx count", rd[5:0], 6'h2);
    apb(1'b1, 8'h0C, 32'h40);
    apb(1'b0, 8'h1C, 32'h0);
    chk("rx count", rd[5:0], 6'h0);
    rdchk("status", 8'h00, 32'h80);
    // timer runs 16 cycles, flag lands one edge later
    apb(1'b1, 8'h0C, 32'h10);
    repeat (30) @(posedge pclk);
    rdchk("status", 8'h00, 32'h08);
    // fill, drain, release pool
    for (i = 0; i < 32; i++) u_line.send(i[7:0], 1'b0);
    rdchk("status", 8'h00, 32'h40);
    for (i = 0; i < 32; i++) rdchk("rx byte", 8'h14, i);
    apb(1'b1, 8'h0C, 32'h80);
    // auto mode: peer status, bad S frame, RNR
    apb(1'b1, 8'h18, 32'h1);
    u_line.send(8'h01, 1'b1, 8'h50);
    u_line.send(8'h02, 1'b1, 8'h51);
    apb(1'b1, 8'h0C, 32'h20);
    u_line.send(8'h03, 1'b1, 8'h40);
    rdchk("status", 8'h00, 32'hA1);
    rdchk("ext", 8'h08, 32'h30);
    chk("ack rnr", ack_rnr, 1'b1);
    conclude;
  end
endmodule
